//--- hdl/avf_formatter.sv
// Analog value formatter: sample encoding, setpoint decoding, process data latch
//
// Added by the designer: the register addresses and the APB register port.
`default_nettype none
module avf_formatter #(
  parameter int unsigned CYC_10MS = avf_pkg::CYCLE_MS * (avf_pkg::CLK_HZ / 1000),
  parameter int unsigned CYC_20MS = avf_pkg::REF10_OUT_MS * (avf_pkg::CLK_HZ / 1000),
  parameter int unsigned CYC_40MS = avf_pkg::REF10_IN_MS * (avf_pkg::CLK_HZ / 1000),
  parameter int unsigned CYC_60MS = avf_pkg::REF10_IO_MS * (avf_pkg::CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter samples
  input wire logic sample_valid,
  input wire logic signed [31:0] sample_value,
  output logic sample_ready,
  // Process data exchange
  output logic pd_tick,
  output logic [23:0] pd_in_bytes,
  input wire logic pd_out_strobe,
  input wire logic [15:0] pd_out_word,
  // Output stage setpoint
  output logic signed [31:0] setpoint,
  output logic setpoint_valid
);
  import avf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIN} avf_st_e;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  logic [CTRL_W-1:0] ctrl_q;
  logic [1:0] fmt;
  logic [4:0] nbits;
  logic aln;
  logic rev10;
  logic [1:0] vari;
  avf_mode_e mode;
  logic is_cur;
  logic offs_cls;
  assign fmt = ctrl_q[C_FMT +: 2];
  assign nbits = avf_bits(ctrl_q[C_RES +: 2]);
  assign aln = ctrl_q[C_ALN];
  assign rev10 = ctrl_q[C_REV];
  assign vari = ctrl_q[C_VAR +: 2];
  assign mode = avf_mode_e'(ctrl_q[C_MODE +: 4]);
  assign is_cur = (mode == M_I4_20) || (mode == M_I0_20);
  // Offset-from-minimum scaling classes
  assign offs_cls = (fmt == FMT_UNSIGNED) || is_cur || (mode == M_V5_10);

  ////////////////////////////////////////////////////////////////////////////
  // State
  avf_st_e st_q;
  logic job_q;
  logic neg_q;
  logic uns_q;
  logic aln_q;
  logic [4:0] n_q;
  logic [15:0] lim_q;
  logic signed [31:0] add_q;
  logic [31:0] quo_q;
  logic [32:0] rem_q;
  logic [31:0] den_q;
  logic [4:0] cnt_q;
  logic [15:0] enc_word_q;
  logic signed [31:0] setpoint_q;
  logic spv_q;
  logic dec_pend_q;
  logic [15:0] out_q;
  logic enc_go;
  logic dec_go;
  assign sample_ready = (st_q == ST_IDLE) && !dec_pend_q;
  assign enc_go = sample_valid && sample_ready;
  assign dec_go = dec_pend_q && (st_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Encode setup
  logic [63:0] ilim;
  logic signed [32:0] e_diff;
  logic [32:0] e_mag;
  logic [47:0] e_prod;
  logic [31:0] e_num;
  logic [31:0] e_den;
  logic [15:0] e_lim;
  logic e_neg;
  always_comb begin
    ilim = avf_limits(mode, 1'b0);
    e_lim = (fmt == FMT_UNSIGNED) ? avf_fs(nbits) : avf_hs(nbits);
    e_den = offs_cls ? 32'(ilim[31:0] - ilim[63:32]) : ilim[31:0];
    e_diff = offs_cls ? 33'(sample_value - $signed(ilim[63:32])) : 33'(sample_value);
    e_neg = e_diff[32] && !offs_cls;
    e_mag = e_diff[32] ? (offs_cls ? 33'h0 : 33'(-e_diff)) : 33'(e_diff);
    e_prod = e_mag[31:0] * e_lim;
    e_num = (e_prod[47:32] != 16'h0000) ? 32'hFFFF_FFFF : e_prod[31:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode setup
  logic [63:0] olim;
  logic [15:0] d_code;
  logic [15:0] d_mag;
  logic [47:0] d_prod;
  logic [31:0] d_den;
  logic d_neg;
  logic signed [31:0] d_add;
  logic signed [31:0] d_dim;
  always_comb begin
    olim = avf_limits(mode, 1'b1);
    d_code = avf_unalign(out_q, nbits, aln);
    d_neg = (fmt == FMT_SIGNED) && !offs_cls && avf_msb(d_code, nbits);
    d_mag = d_neg ? 16'(17'((18'h00001 << nbits) - {2'b00, d_code})) : d_code;
    d_prod = offs_cls ? d_mag * 32'(olim[31:0] - olim[63:32]) : d_mag * olim[31:0];
    d_den = {16'h0000, (fmt == FMT_UNSIGNED) ? avf_fs(nbits) : avf_hs(nbits)};
    d_add = offs_cls ? $signed(olim[63:32]) : 32'sd0;
    d_dim = is_cur ? $signed({16'h0000, out_q}) : $signed({{16{out_q[15]}}, out_q});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Finish stage
  logic [32:0] trial;
  logic [15:0] f_q;
  logic [15:0] f_code;
  assign trial = {rem_q[31:0], quo_q[31]};
  always_comb begin
    f_q = (quo_q > {16'h0000, lim_q}) ? lim_q : quo_q[15:0];
    f_code = (neg_q ? 16'(~f_q + 16'h0001) : f_q) & avf_fs(n_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared divider and job sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      job_q <= 1'b0;
      neg_q <= 1'b0;
      uns_q <= 1'b0;
      aln_q <= 1'b0;
      n_q <= 5'h10;
      lim_q <= 16'h0000;
      add_q <= 32'sd0;
      quo_q <= 32'h0;
      rem_q <= 33'h0;
      den_q <= 32'h1;
      cnt_q <= 5'h00;
      enc_word_q <= 16'h0000;
      setpoint_q <= 32'sd0;
      spv_q <= 1'b0;
    end else begin
      spv_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          n_q <= nbits;
          aln_q <= aln;
          uns_q <= (fmt == FMT_UNSIGNED);
          rem_q <= 33'h0;
          cnt_q <= 5'h1F;
          if (dec_go) begin
            job_q <= 1'b1;
            neg_q <= d_neg;
            add_q <= d_add;
            if (fmt == FMT_DIM) begin
              setpoint_q <= d_dim;
              spv_q <= 1'b1;
            end else begin
              quo_q <= d_prod[31:0];
              den_q <= d_den;
              st_q <= ST_DIV;
            end
          end else if (enc_go) begin
            job_q <= 1'b0;
            neg_q <= e_neg;
            lim_q <= e_lim;
            if (fmt == FMT_DIM) begin
              enc_word_q <= sample_value[15:0];
            end else begin
              quo_q <= e_num;
              den_q <= e_den;
              st_q <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if (trial >= {1'b0, den_q}) begin
            rem_q <= 33'(trial - {1'b0, den_q});
            quo_q <= {quo_q[30:0], 1'b1};
          end else begin
            rem_q <= trial;
            quo_q <= {quo_q[30:0], 1'b0};
          end
          cnt_q <= cnt_q - 5'h01;
          if (cnt_q == 5'h00) begin
            st_q <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (job_q) begin
            setpoint_q <= (neg_q ? -$signed(quo_q) : $signed(quo_q)) + add_q;
            spv_q <= 1'b1;
          end else begin
            enc_word_q <= avf_align(f_code, n_q, aln_q);
          end
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign setpoint = setpoint_q;
  assign setpoint_valid = spv_q;

  ////////////////////////////////////////////////////////////////////////////
  // Received output word; new arrival beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 16'h0000;
      dec_pend_q <= 1'b0;
    end else if (pd_out_strobe && (vari != VAR_IN)) begin
      out_q <= pd_out_word;
      dec_pend_q <= 1'b1;
    end else if (dec_go) begin
      dec_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process data refresh timer and latch
  logic [19:0] per_cyc;
  logic [7:0] per_ms;
  logic [19:0] tmr_q;
  logic tick_q;
  logic [23:0] pd_in_q;
  always_comb begin
    if (!rev10) begin
      per_cyc = 20'(CYC_10MS);
      per_ms = 8'(CYCLE_MS);
    end else if (vari == VAR_OUT) begin
      per_cyc = 20'(CYC_20MS);
      per_ms = 8'(REF10_OUT_MS);
    end else if (vari == VAR_INOUT) begin
      per_cyc = 20'(CYC_60MS);
      per_ms = 8'(REF10_IO_MS);
    end else begin
      per_cyc = 20'(CYC_40MS);
      per_ms = 8'(REF10_IN_MS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 20'h00000;
      tick_q <= 1'b0;
      pd_in_q <= 24'h000000;
    end else if (tmr_q >= per_cyc - 20'h00001) begin
      tmr_q <= 20'h00000;
      tick_q <= 1'b1;
      pd_in_q <= {enc_word_q, PD_STATUS};
    end else begin
      tmr_q <= tmr_q + 20'h00001;
      tick_q <= 1'b0;
    end
  end
  assign pd_tick = tick_q;
  assign pd_in_bytes = pd_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB register file, zero wait states
  logic [31:0] link_word;
  logic [31:0] rd_d;
  logic err_d;
  logic [31:0] prdata_q;
  logic err_q;
  always_comb begin
    link_word = {rev10 ? REV10 : REV11, rev10 ? FRAME_1 : FRAME_2V,
                 (vari == VAR_OUT) ? 4'h0 : PD_IN_BYTES, (vari == VAR_IN) ? 4'h0 : PD_OUT_BYTES, per_ms};
    rd_d = 32'h0;
    err_d = pwrite && (paddr != A_CTRL);
    case (paddr)
      A_CTRL: rd_d = {20'h00000, ctrl_q};
      A_STAT: rd_d = {30'h0, dec_pend_q, st_q != ST_IDLE};
      A_WORD: rd_d = {16'h0000, enc_word_q};
      A_SETP: rd_d = setpoint_q;
      A_LINK: rd_d = link_word;
      A_BAUD: rd_d = MEDIUM_BAUD_RATE;
      default: err_d = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= rd_d;
      err_q <= err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (psel && penable && pwrite && (paddr == A_CTRL)) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = err_q && psel && penable;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [20:0] gap_q;
  logic [19:0] per_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 21'h0;
      per_q <= 20'h00000;
    end else begin
      per_q <= per_cyc;
      // Restart on a tick or on a period change
      gap_q <= (tick_q || (per_q != per_cyc)) ? 21'h1 : gap_q + 21'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  dim_word_a: assert property (enc_go && fmt == FMT_DIM |=> enc_word_q == $past(sample_value[15:0]))
    else $error("dimensioned word not passed through");
  word_mask_a: assert property (st_q == ST_FIN && !job_q |=>
    (enc_word_q & ~avf_align(avf_fs(n_q), n_q, aln_q)) == 16'h0000) else $error("stray bits in word");
  sign_set_a: assert property (st_q == ST_FIN && !job_q && !uns_q && neg_q && quo_q != 32'h0 |=>
    avf_msb(avf_unalign(enc_word_q, n_q, aln_q), n_q)) else $error("negative code lacks sign");
  sign_clear_a: assert property (st_q == ST_FIN && !job_q && !uns_q && !neg_q |=>
    !avf_msb(avf_unalign(enc_word_q, n_q, aln_q), n_q)) else $error("positive code has sign");
  full_scale_a: assert property (st_q == ST_FIN && !job_q && uns_q && quo_q >= {16'h0000, lim_q} |=>
    avf_unalign(enc_word_q, n_q, aln_q) == avf_fs(n_q)) else $error("unsigned full scale wrong");
  job_time_a: assert property (enc_go && fmt != FMT_DIM |=> ##[33:34] st_q == ST_IDLE)
    else $error("conversion time off");
  pd_latch_a: assert property (pd_in_bytes != $past(pd_in_bytes) |-> pd_tick)
    else $error("process data changed between transfers");
  refresh_gap_a: assert property (gap_q <= {1'b0, per_q})
    else $error("refresh period exceeded");
  setp_zero_a: assert property (st_q == ST_FIN && job_q && quo_q == 32'h0 |=>
    setpoint_valid && setpoint == $past(add_q)) else $error("zero code setpoint not at limit");
  apb_err_a: assert property (psel && !penable && err_d |=> pslverr) else $error("bad access not flagged");

  dim_c: cover property (enc_go && fmt == FMT_DIM);
  neg_c: cover property (st_q == ST_FIN && !job_q && neg_q);
  dec_c: cover property (setpoint_valid && st_q == ST_IDLE);
  tick_c: cover property (pd_tick && rev10);

endmodule : avf_formatter
`default_nettype wire

//--- hdl/avf_pkg.sv
// Constants, types and helpers for the analog value formatter
`default_nettype none
package avf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and control field layout
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_WORD = 8'h08;
  localparam logic [7:0] A_SETP = 8'h0C;
  localparam logic [7:0] A_LINK = 8'h10;
  localparam logic [7:0] A_BAUD = 8'h14;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam int C_FMT = 0;
  localparam int C_RES = 2;
  localparam int C_ALN = 4;
  localparam int C_REV = 5;
  localparam int C_VAR = 6;
  localparam int C_MODE = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] FMT_SIGNED = 2'h0;
  localparam logic [1:0] FMT_UNSIGNED = 2'h1;
  localparam logic [1:0] FMT_DIM = 2'h2;
  localparam logic [1:0] VAR_IN = 2'h0;
  localparam logic [1:0] VAR_OUT = 2'h1;
  localparam logic [1:0] VAR_INOUT = 2'h2;
  typedef enum logic [3:0] {
    M_V0_10, M_V5_10, M_VPM10, M_V0_5, M_VPM5, M_I4_20, M_I0_20,
    M_PT100, M_PT1000, M_TJ_UNG, M_TJ_GND, M_TK_UNG, M_TK_GND
  } avf_mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // Link figures
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYCLE_MS = 10;
  localparam int unsigned REF10_IN_MS = 40;
  localparam int unsigned REF10_OUT_MS = 20;
  localparam int unsigned REF10_IO_MS = 60;
  localparam logic [31:0] MEDIUM_BAUD_RATE = 32'h0000_9600;
  localparam logic [7:0] REV11 = 8'h11;
  localparam logic [7:0] REV10 = 8'h10;
  localparam logic [7:0] FRAME_2V = 8'h2F;
  localparam logic [7:0] FRAME_1 = 8'h01;
  localparam logic [3:0] PD_IN_BYTES = 4'h3;
  localparam logic [3:0] PD_OUT_BYTES = 4'h2;
  localparam logic [7:0] PD_STATUS = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [4:0] avf_bits(input logic [1:0] r);
    case (r)
      2'h0: avf_bits = 5'h10;
      2'h1: avf_bits = 5'h0E;
      2'h2: avf_bits = 5'h0C;
      default: avf_bits = 5'h0A;
    endcase
  endfunction : avf_bits

  function automatic logic [15:0] avf_fs(input logic [4:0] n);
    avf_fs = 16'(17'((18'h00001 << n) - 18'h00001));
  endfunction : avf_fs

  function automatic logic [15:0] avf_hs(input logic [4:0] n);
    avf_hs = avf_fs(n) >> 1;
  endfunction : avf_hs

  function automatic logic [15:0] avf_align(input logic [15:0] c, input logic [4:0] n, input logic l);
    avf_align = l ? 16'(c << (5'h10 - n)) : c;
  endfunction : avf_align

  function automatic logic [15:0] avf_unalign(input logic [15:0] w, input logic [4:0] n, input logic l);
    avf_unalign = l ? (w >> (5'h10 - n)) : (w & avf_fs(n));
  endfunction : avf_unalign

  function automatic logic avf_msb(input logic [15:0] c, input logic [4:0] n);
    avf_msb = c[4'(n - 5'h01)];
  endfunction : avf_msb

  // Range limits {min,max}: mV, uA or 0.1 degC; out selects nominal range
  function automatic logic [63:0] avf_limits(input avf_mode_e m, input logic out);
    case (m)
      M_V0_10: avf_limits = out ? {32'sd0, 32'sd10000} : {-32'sd500, 32'sd10500};
      M_V5_10: avf_limits = out ? {32'sd5000, 32'sd10000} : {32'sd4500, 32'sd10500};
      M_VPM10: avf_limits = out ? {-32'sd10000, 32'sd10000} : {-32'sd10500, 32'sd10500};
      M_V0_5: avf_limits = out ? {32'sd0, 32'sd5000} : {-32'sd500, 32'sd5500};
      M_VPM5: avf_limits = out ? {-32'sd5000, 32'sd5000} : {-32'sd5500, 32'sd5500};
      M_I4_20: avf_limits = out ? {32'sd4000, 32'sd20000} : {32'sd3800, 32'sd20500};
      M_I0_20: avf_limits = out ? {32'sd0, 32'sd20000} : {32'sd0, 32'sd20500};
      M_TJ_UNG: avf_limits = {-32'sd1000, 32'sd12000};
      M_TK_UNG: avf_limits = {-32'sd1800, 32'sd13700};
      M_TJ_GND, M_TK_GND: avf_limits = {-32'sd1000, 32'sd4000};
      default: avf_limits = {-32'sd2000, 32'sd8500};
    endcase
  endfunction : avf_limits

endpackage : avf_pkg
`default_nettype wire

//--- sim/avf_master_model.sv
// Process data master model: collects input bytes, measures refresh, sends output words
`default_nettype none
module avf_master_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Process data from the device
  input wire logic pd_tick,
  input wire logic [23:0] pd_in_bytes,
  // Output words to the device
  output logic pd_out_strobe,
  output logic [15:0] pd_out_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tick_d;
  logic [23:0] last_in;
  logic [15:0] cnt;
  logic [15:0] last_period;
  int n_ticks;

  initial begin
    pd_out_strobe = 1'b0;
    pd_out_word = 16'hA5A5;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh period and input word capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d <= 1'b0;
      last_in <= 24'h000000;
      cnt <= 16'h0000;
      last_period <= 16'h0000;
      n_ticks <= 0;
    end else begin
      tick_d <= pd_tick;
      if (tick_d) begin
        last_in <= pd_in_bytes;
      end
      if (pd_tick) begin
        last_period <= cnt;
        cnt <= 16'h0001;
        n_ticks <= n_ticks + 1;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One output word; the bus shows its inverse when idle
  task automatic send(input logic [15:0] w);
    @(posedge pclk);
    pd_out_strobe <= 1'b1;
    pd_out_word <= w;
    @(posedge pclk);
    pd_out_strobe <= 1'b0;
    pd_out_word <= ~w;
  endtask : send
endmodule : avf_master_model
`default_nettype wire

//--- sim/tb_top.sv
// Testbench for the analog value formatter with a process data master model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import avf_pkg::*;
  typedef struct packed {logic [11:0] c; logic [31:0] x; logic [15:0] w;} avf_enc_s;
  typedef struct packed {logic [11:0] c; logic [15:0] w; logic [31:0] s;} avf_dec_s;
  typedef struct packed {logic [11:0] c; logic [31:0] l; logic [15:0] p;} avf_lnk_s;
  localparam avf_enc_s ENC [21] = '{
    '{12'h004, 32'sd5974, 16'h1234}, '{12'h218, -32'sd6915, 16'hABC0}, '{12'h005, 32'sd5562, 16'h2344},
    '{12'h519, 32'sd15007, 16'hABC0}, '{12'h901, 32'sd2524, 16'h4565}, '{12'h01E, -32'sd5000, 16'hEC78},
    '{12'h51E, 32'sd15007, 16'h3A9F}, '{12'h902, 32'sd1777, 16'h06F1}, '{12'h702, -32'sd1500, 16'hFA24},
    '{12'h500, 32'sd12000, 16'h3ED9}, '{12'h10C, 32'sd7500, 16'h00FF}, '{12'h70C, -32'sd1000, 16'h03C4},
    '{12'h71C, -32'sd1000, 16'hF100}, '{12'hB00, 32'sd6850, 16'h3FFF}, '{12'h301, 32'sd5500, 16'hFFFF},
    '{12'h301, -32'sd500, 16'h0000}, '{12'h40D, 32'sd5500, 16'h03FF}, '{12'h60D, 32'sd20500, 16'h03FF},
    '{12'h80D, 32'sd8500, 16'h03FF}, '{12'hA0D, 32'sd4000, 16'h03FF}, '{12'hC0D, 32'sd4000, 16'h03FF}};
  localparam avf_dec_s DEC [7] = '{
    '{12'h580, 16'h4000, 32'sd12000}, '{12'h381, 16'h8000, 32'sd2500}, '{12'h099, 16'hFFF0, 32'sd10000},
    '{12'h298, 16'hABC0, -32'sd6585}, '{12'h582, 16'hC350, 32'sd50000}, '{12'h082, 16'hEC78, -32'sd5000},
    '{12'h580, 16'h0000, 32'sd4000}};
  localparam avf_lnk_s LNK [5] = '{
    '{12'h000, {REV11, FRAME_2V, 16'h300A}, 16'h0014}, '{12'h020, {REV10, FRAME_1, 16'h3028}, 16'h0050},
    '{12'h060, {REV10, FRAME_1, 16'h0214}, 16'h0028}, '{12'h0A0, {REV10, FRAME_1, 16'h323C}, 16'h0078},
    '{12'h080, {REV11, FRAME_2V, 16'h320A}, 16'h0014}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, sample_ready;
  logic pd_tick, pd_out_strobe, setpoint_valid, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [31:0] sample_value, setpoint;
  logic [23:0] pd_in_bytes;
  logic [15:0] pd_out_word;
  int n_errors, compares, cyc;

  avf_formatter #(.CYC_10MS(20), .CYC_20MS(40), .CYC_40MS(80), .CYC_60MS(120)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_value(sample_value), .sample_ready(sample_ready), .pd_tick(pd_tick), .pd_in_bytes(pd_in_bytes),
    .pd_out_strobe(pd_out_strobe), .pd_out_word(pd_out_word), .setpoint(setpoint),
    .setpoint_valid(setpoint_valid));
  avf_master_model master (.pclk(pclk), .presetn(presetn), .pd_tick(pd_tick), .pd_in_bytes(pd_in_bytes),
    .pd_out_strobe(pd_out_strobe), .pd_out_word(pd_out_word));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and verdict
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // Bus and stream tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_ticks(input int k);
    int t0;
    t0 = master.n_ticks;
    while (master.n_ticks < t0 + k) @(negedge pclk);
  endtask : wait_ticks
  task automatic encode(input avf_enc_s e);
    apb(1'b1, A_CTRL, {20'h0, e.c});
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_value <= e.x;
    do @(posedge pclk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
    sample_value <= ~e.x;
    do @(negedge pclk); while (sample_ready !== 1'b1);
    apb(1'b0, A_WORD, 32'h0);
    chk(rd, {16'h0, e.w}, "encoded word");
  endtask : encode
  task automatic decode(input logic [11:0] c, input logic [15:0] w, output int hits);
    int n;
    apb(1'b1, A_CTRL, {20'h0, c});
    master.send(w);
    hits = 0;
    for (n = 0; n < 60; n++) begin
      @(negedge pclk);
      if (setpoint_valid === 1'b1) hits++;
    end
  endtask : decode

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int i;
    int hits;
    {presetn, psel, penable, pwrite, sample_valid} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_value = 32'sd0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({31'h0, sample_ready}, 32'h1, "ready after reset");
    chk(setpoint, 32'h0, "setpoint after reset");
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, {20'h0, CTRL_RST}, "control reset");
    apb(1'b1, A_CTRL, 32'hFFFF_F2D5);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0000_02D5, "control readback");
    apb(1'b1, A_STAT, 32'h1);
    chk({31'h0, er}, 32'h1, "write to read-only");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b0, A_BAUD, 32'h0);
    chk(rd, 32'h0000_9600, "baud");
    for (i = 0; i < 21; i++) encode(ENC[i]);
    wait_ticks(2);
    chk({8'h0, master.last_in}, {8'h0, ENC[20].w, 8'h00}, "input bytes");
    for (i = 0; i < 7; i++) begin
      decode(DEC[i].c, DEC[i].w, hits);
      chk({31'h0, hits == 1}, 32'h1, "setpoint pulse count");
      chk(setpoint, DEC[i].s, "setpoint");
      apb(1'b0, A_SETP, 32'h0);
      chk(rd, DEC[i].s, "setpoint register");
    end
    decode(12'h000, 16'h4000, hits);
    chk(hits, 32'h0, "strobe in input-only variant");
    for (i = 0; i < 5; i++) begin
      apb(1'b1, A_CTRL, {20'h0, LNK[i].c});
      apb(1'b0, A_LINK, 32'h0);
      chk(rd, LNK[i].l, "link figures");
      wait_ticks(3);
      chk({16'h0, master.last_period}, {16'h0, LNK[i].p}, "refresh period");
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
